// ---- sim/timing_select_config_test.sv ----
// Self-checking testbench of the timing select configuration block
`timescale 1ns/100ps
module timing_select_config_test;
  // Short watchdog exponents keep the run brief
  localparam int E0 = 4;
  localparam int E1 = 5;
  localparam int E2 = 6;
  localparam int E3 = 7;

  logic        sys_clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        wdt_restart;
  logic [26:0] wdt_int_timeout;
  logic [26:0] wdt_rst_timeout;
  logic        wdt_reset_pulse;
  logic [2:0]  stretch_value;
  logic [3:0]  external_data_move_cycles;
  logic        t3_count_en;
  logic        irq;
  int          n_fail;
  int          n_tests;
  int          cyc;

  tsc_timing_select #(.WDT_EXP0(E0), .WDT_EXP1(E1), .WDT_EXP2(E2),
                      .WDT_EXP3(E3)) u_tsc_timing_select (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .wdt_restart     (wdt_restart),
    .wdt_int_timeout (wdt_int_timeout),
    .wdt_rst_timeout (wdt_rst_timeout),
    .wdt_reset_pulse (wdt_reset_pulse),
    .stretch_value   (stretch_value),
    .external_data_move_cycles     (external_data_move_cycles),
    .t3_count_en     (t3_count_en),
    .irq             (irq)
  );

  always #20 sys_clk = ~sys_clk;

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Run is well under 3000 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      print_verdict;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task t_reset_values;
    logic [7:0] d;
    // Look after the release edge has settled
    #1;
    chk({29'h0, stretch_value}, 32'h1);
    chk({28'h0, external_data_move_cycles}, 32'h3);
    rd(tsc_pkg::ADDR_CLK_CTRL, d);
    chk({24'h0, d}, 32'h01);
    rd(tsc_pkg::ADDR_T3_PRESCALE, d);
    chk({24'h0, d}, 32'h00);
    rd(tsc_pkg::ADDR_IRQ_MASK, d);
    chk({24'h0, d}, 32'h00);
    // Unmapped place must read as zero
    rd(8'h55, d);
    chk({24'h0, d}, 32'h00);
  endtask : t_reset_values

  task t_wdt_periods;
    int         e[4];
    logic [7:0] d;
    e = '{E0, E1, E2, E3};
    for (int s = 0; s < 4; s++) begin
      wr(tsc_pkg::ADDR_CLK_CTRL, {s[1:0], 6'h01});
      settle;
      chk({5'h0, wdt_int_timeout}, 32'h1 << e[s]);
      chk({5'h0, wdt_rst_timeout}, (32'h1 << e[s]) + 32'h200);
      rd(tsc_pkg::ADDR_CLK_CTRL, d);
      chk({24'h0, d}, {24'h0, s[1:0], 6'h01});
    end
  endtask : t_wdt_periods

  task t_stretch;
    logic [7:0] d;
    for (int s = 0; s < 8; s++) begin
      // Bits 5:3 belong elsewhere and must not stick
      wr(tsc_pkg::ADDR_CLK_CTRL, {5'h07, s[2:0]});
      settle;
      chk({29'h0, stretch_value}, {29'h0, s[2:0]});
      chk({28'h0, external_data_move_cycles}, 32'(s + 2));
      rd(tsc_pkg::ADDR_CLK_CTRL, d);
      chk({24'h0, d}, {29'h0, s[2:0]});
    end
  endtask : t_stretch

  task t_prescale;
    int         dv[4];
    int         n;
    logic [7:0] d;
    dv = '{1, 4, 16, 32};
    for (int s = 0; s < 4; s++) begin
      wr(tsc_pkg::ADDR_T3_PRESCALE, {6'h3F, s[1:0]});
      rd(tsc_pkg::ADDR_T3_PRESCALE, d);
      chk({24'h0, d}, {30'h0, s[1:0]});
      repeat (40) @(posedge sys_clk);
      n = 0;
      // 64 cycles hold a whole number of periods for every divider
      repeat (64) begin
        @(posedge sys_clk);
        #1;
        if (t3_count_en === 1'b1) n++;
      end
      chk(32'(n), 32'(64 / dv[s]));
    end
  endtask : t_prescale

  task t_wdt_irq;
    int         n;
    int         n_irq;
    logic [7:0] d;
    wr(tsc_pkg::ADDR_T3_PRESCALE, 8'h00);
    wr(tsc_pkg::ADDR_CLK_CTRL, 8'h01);
    @(posedge sys_clk);
    wdt_restart <= 1'b1;
    wr(tsc_pkg::ADDR_IRQ_STATUS, 8'h07);
    wr(tsc_pkg::ADDR_IRQ_MASK, 8'h02);
    settle;
    chk({31'h0, irq}, 32'h0);
    @(posedge sys_clk);
    wdt_restart <= 1'b0;
    n = 0;
    n_irq = 0;
    while (wdt_reset_pulse !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (irq === 1'b1 && n_irq == 0) n_irq = n;
    end
    chk(32'(n_irq), 32'(1 << E0));
    chk(32'(n), 32'((1 << E0) + 512));
    chk({31'h0, irq}, 32'h1);
    rd(tsc_pkg::ADDR_IRQ_STATUS, d);
    @(posedge sys_clk);
    wdt_restart <= 1'b1;
    chk({30'h0, d[2:1]}, 32'h3);
    wr(tsc_pkg::ADDR_IRQ_STATUS, 8'h06);
    rd(tsc_pkg::ADDR_IRQ_STATUS, d);
    chk({30'h0, d[2:1]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(tsc_pkg::ADDR_IRQ_MASK, 8'h01);
    settle;
    chk({31'h0, irq}, 32'h1);
    wr(tsc_pkg::ADDR_IRQ_MASK, 8'h00);
    settle;
    chk({31'h0, irq}, 32'h0);
  endtask : t_wdt_irq

  initial begin
    sys_clk     = 1'b0;
    reset_n     = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    wdt_restart = 1'b0;
    n_fail      = 0;
    n_tests     = 0;
    cyc         = 0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset_values;
    t_wdt_periods;
    t_stretch;
    t_prescale;
    t_wdt_irq;
    print_verdict;
  end
endmodule : timing_select_config_test

// ---- verilog/tsc_pkg.sv ----
// Package: register map, field layout, reset values and counts of the block
package tsc_pkg;

  localparam logic [7:0] ADDR_CLK_CTRL     = 8'h8E;
  localparam logic [7:0] ADDR_T3_PRESCALE  = 8'h8F;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'hA1;

  localparam int         WDT_SEL_LSB       = 6;
  localparam int         STRETCH_LSB       = 0;
  localparam int         T3_SEL_LSB        = 0;

  localparam logic [7:0] CLK_CTRL_RESET    = 8'h01;
  localparam logic [7:0] T3_PRESCALE_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET    = 3'h0;

  localparam int         IRQ_W             = 3;
  localparam int         IRQ_T3_TICK       = 0;
  localparam int         IRQ_WDT_INT       = 1;
  localparam int         IRQ_WDT_RST       = 2;

  localparam int         WDT_EXP_SEL0      = 17;
  localparam int         WDT_EXP_SEL1      = 20;
  localparam int         WDT_EXP_SEL2      = 23;
  localparam int         WDT_EXP_SEL3      = 26;
  localparam int         WDT_W             = 27;
  localparam logic [26:0] WDT_RST_EXTRA    = 27'h0000200;

  localparam logic [3:0] EXTERNAL_DATA_MOVE_BASE_CYCLES  = 4'h2;

  localparam logic [4:0] T3_LAST_SEL0      = 5'h00;
  localparam logic [4:0] T3_LAST_SEL1      = 5'h03;
  localparam logic [4:0] T3_LAST_SEL2      = 5'h0F;
  localparam logic [4:0] T3_LAST_SEL3      = 5'h1F;

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } tsc_pre_state_s;

  typedef struct packed {
    logic [1:0]  wdt_sel;
    logic [2:0]  stretch;
    logic [1:0]  pre_sel;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [7:0]  rdata;
    logic [26:0] int_to;
    logic [26:0] rst_to;
    logic [3:0]  external_data_move;
    logic [26:0] wdt_cnt;
    logic        wdt_rst;
  } tsc_top_state_s;

endpackage : tsc_pkg

// ---- verilog/tsc_pre_if.sv ----
// Interface: prescale select and count enable between control and prescaler
`timescale 1ns/100ps
interface tsc_pre_if;
  logic [1:0] sel;
  logic       tick;
  modport ctl (output sel, input tick);
  modport pre (input sel, output tick);
endinterface : tsc_pre_if

// ---- verilog/tsc_t3_prescaler.sv ----
// Free-running timer 3 prescaler with one-cycle count enable
`timescale 1ns/100ps
module tsc_t3_prescaler (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  tsc_pre_if.pre    pre
);

  tsc_pkg::tsc_pre_state_s s_q;
  tsc_pkg::tsc_pre_state_s s_d;
  logic [4:0]              last;

  function automatic logic [4:0] div_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_last = tsc_pkg::T3_LAST_SEL0;
      2'h1: div_last = tsc_pkg::T3_LAST_SEL1;
      2'h2: div_last = tsc_pkg::T3_LAST_SEL2;
      2'h3: div_last = tsc_pkg::T3_LAST_SEL3;
    endcase
  endfunction : div_last

  always_comb begin
    last = div_last(pre.sel);
    s_d  = s_q;
    // A shorter divide chosen mid-count wraps at once instead of running on
    if (s_q.cnt >= last) begin
      s_d.cnt  = 5'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt  = s_q.cnt + 5'h01;
      s_d.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pre.tick = s_q.tick;

  property p_div1;
    @(posedge sys_clk) disable iff (!reset_n)
      (pre.sel == 2'h0)[*2] |-> ##1 pre.tick;
  endproperty
  a_div1: assert property (p_div1)
    else $error("divide by 1 lost a tick");

  property p_div4;
    @(posedge sys_clk) disable iff (!reset_n)
      (pre.tick && pre.sel == 2'h1) ##1 (pre.sel == 2'h1)[*3]
        |-> !pre.tick && !$past(pre.tick) && !$past(pre.tick, 2)
            ##1 pre.tick;
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide by 4 period wrong");

  property p_div16;
    @(posedge sys_clk) disable iff (!reset_n)
      (pre.tick && pre.sel == 2'h2) ##1 (pre.sel == 2'h2)[*8]
        |-> !pre.tick && !$past(pre.tick, 4) && !$past(pre.tick, 7);
  endproperty
  a_div16: assert property (p_div16)
    else $error("divide by 16 ticks early");

  property p_tick_one;
    @(posedge sys_clk) disable iff (!reset_n)
      (pre.tick && pre.sel != 2'h0) ##1 (pre.sel != 2'h0) |-> !pre.tick;
  endproperty
  a_tick_one: assert property (p_tick_one)
    else $error("tick longer than one");

endmodule : tsc_t3_prescaler

// ---- verilog/tsc_timing_select.sv ----
// Timing select configuration: watchdog periods, data move stretch, prescale
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module tsc_timing_select #(
  parameter int WDT_EXP0 = tsc_pkg::WDT_EXP_SEL0,
  parameter int WDT_EXP1 = tsc_pkg::WDT_EXP_SEL1,
  parameter int WDT_EXP2 = tsc_pkg::WDT_EXP_SEL2,
  parameter int WDT_EXP3 = tsc_pkg::WDT_EXP_SEL3
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output wire logic [7:0]  reg_rdata,
  input  wire logic        wdt_restart,
  output wire logic [26:0] wdt_int_timeout,
  output wire logic [26:0] wdt_rst_timeout,
  output wire logic        wdt_reset_pulse,
  output wire logic [2:0]  stretch_value,
  output wire logic [3:0]  external_data_move_cycles,
  output wire logic        t3_count_en,
  output wire logic        irq
);

  tsc_pkg::tsc_top_state_s s_q;
  tsc_pkg::tsc_top_state_s s_d;
  tsc_pre_if               pre_bus ();
  logic [2:0]              events;
  logic [7:0]              rd_word;

  localparam logic [2:0] STRETCH_RST =
    tsc_pkg::CLK_CTRL_RESET[tsc_pkg::STRETCH_LSB +: 3];

  // Time-outs come from exponents so a simulation can shrink them
  function automatic logic [26:0] wdt_int_count(input logic [1:0] sel);
    unique case (sel)
      2'h0: wdt_int_count = 27'h0000001 << WDT_EXP0;
      2'h1: wdt_int_count = 27'h0000001 << WDT_EXP1;
      2'h2: wdt_int_count = 27'h0000001 << WDT_EXP2;
      2'h3: wdt_int_count = 27'h0000001 << WDT_EXP3;
    endcase
  endfunction : wdt_int_count

  tsc_t3_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pre     (pre_bus.pre)
  );

  assign pre_bus.sel = s_q.pre_sel;

  always_comb begin
    s_d = s_q;

    // Configuration writes
    if (reg_wr) begin
      unique case (reg_addr)
        tsc_pkg::ADDR_CLK_CTRL: begin
          s_d.wdt_sel = reg_wdata[tsc_pkg::WDT_SEL_LSB +: 2];
          s_d.stretch = reg_wdata[tsc_pkg::STRETCH_LSB +: 3];
        end
        tsc_pkg::ADDR_T3_PRESCALE: begin
          s_d.pre_sel = reg_wdata[tsc_pkg::T3_SEL_LSB +: 2];
        end
        tsc_pkg::ADDR_IRQ_MASK: begin
          s_d.irq_mask = reg_wdata[tsc_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Decoded values follow the stored selects one cycle later
    s_d.int_to = wdt_int_count(s_q.wdt_sel);
    s_d.rst_to = wdt_int_count(s_q.wdt_sel)
                 + tsc_pkg::WDT_RST_EXTRA;
    s_d.external_data_move   = {1'b0, s_q.stretch} + tsc_pkg::EXTERNAL_DATA_MOVE_BASE_CYCLES;

    // Watchdog counter runs against the decoded time-outs
    s_d.wdt_rst = 1'b0;
    events      = '0;
    if (wdt_restart) begin
      s_d.wdt_cnt = '0;
    end else if (s_q.wdt_cnt + 27'h0000001 >= s_q.rst_to) begin
      s_d.wdt_cnt = '0;
      s_d.wdt_rst = 1'b1;
      events[tsc_pkg::IRQ_WDT_RST] = 1'b1;
    end else begin
      s_d.wdt_cnt = s_q.wdt_cnt + 27'h0000001;
      if (s_q.wdt_cnt + 27'h0000001 == s_q.int_to) begin
        events[tsc_pkg::IRQ_WDT_INT] = 1'b1;
      end
    end
    events[tsc_pkg::IRQ_T3_TICK] = pre_bus.tick;

    // Write one to clear; a same-cycle event keeps its bit set
    if (reg_wr && reg_addr == tsc_pkg::ADDR_IRQ_STATUS) begin
      s_d.irq_stat = s_q.irq_stat & ~reg_wdata[tsc_pkg::IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | events;

    // Read data stands only in the cycle after the strobe
    rd_word = 8'h00;
    unique case (reg_addr)
      tsc_pkg::ADDR_CLK_CTRL: begin
        rd_word[tsc_pkg::WDT_SEL_LSB +: 2] = s_q.wdt_sel;
        rd_word[tsc_pkg::STRETCH_LSB +: 3] = s_q.stretch;
      end
      tsc_pkg::ADDR_T3_PRESCALE: begin
        rd_word[tsc_pkg::T3_SEL_LSB +: 2] = s_q.pre_sel;
      end
      tsc_pkg::ADDR_IRQ_STATUS: begin
        rd_word[tsc_pkg::IRQ_W-1:0] = s_q.irq_stat;
      end
      tsc_pkg::ADDR_IRQ_MASK: begin
        rd_word[tsc_pkg::IRQ_W-1:0] = s_q.irq_mask;
      end
      default: begin
        rd_word = 8'h00;
      end
    endcase
    s_d.rdata = reg_rd ? rd_word : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q          <= '0;
      s_q.wdt_sel  <= tsc_pkg::CLK_CTRL_RESET[tsc_pkg::WDT_SEL_LSB +: 2];
      s_q.stretch  <= STRETCH_RST;
      s_q.pre_sel  <= tsc_pkg::T3_PRESCALE_RESET[tsc_pkg::T3_SEL_LSB +: 2];
      s_q.irq_mask <= tsc_pkg::IRQ_MASK_RESET;
      s_q.int_to   <= 27'h0000001 << WDT_EXP0;
      s_q.rst_to   <= (27'h0000001 << WDT_EXP0) + tsc_pkg::WDT_RST_EXTRA;
      s_q.external_data_move     <= {1'b0, STRETCH_RST} + tsc_pkg::EXTERNAL_DATA_MOVE_BASE_CYCLES;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata       = s_q.rdata;
  assign wdt_int_timeout = s_q.int_to;
  assign wdt_rst_timeout = s_q.rst_to;
  assign wdt_reset_pulse = s_q.wdt_rst;
  assign stretch_value   = s_q.stretch;
  assign external_data_move_cycles     = s_q.external_data_move;
  assign t3_count_en     = pre_bus.tick;
  assign irq             = |(s_q.irq_stat & s_q.irq_mask);

  // Checks kept beside the logic

  property p_int_decode;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == tsc_pkg::ADDR_CLK_CTRL
        && reg_wdata[7:6] == 2'h3) ##1 !reg_wr[*1]
        |-> ##1 wdt_int_timeout == (27'h0000001 << WDT_EXP3);
  endproperty
  a_int_decode: assert property (p_int_decode)
    else $error("interrupt time-out does not follow select 11");

  property p_int_sel0;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_q.wdt_sel == 2'h0)[*2]
        |-> wdt_int_timeout == (27'h0000001 << WDT_EXP0);
  endproperty
  a_int_sel0: assert property (p_int_sel0)
    else $error("select 00 time-out is not the first period");

  property p_int_sel1;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_q.wdt_sel == 2'h1)[*2]
        |-> wdt_int_timeout == (27'h0000001 << WDT_EXP1);
  endproperty
  a_int_sel1: assert property (p_int_sel1)
    else $error("select 01 time-out is not the second period");

  property p_int_sel2;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_q.wdt_sel == 2'h2)[*2]
        |-> wdt_int_timeout == (27'h0000001 << WDT_EXP2);
  endproperty
  a_int_sel2: assert property (p_int_sel2)
    else $error("select 10 time-out is not the third period");

  property p_int_sel3;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_q.wdt_sel == 2'h3)[*2]
        |-> wdt_int_timeout == (27'h0000001 << WDT_EXP3);
  endproperty
  a_int_sel3: assert property (p_int_sel3)
    else $error("select 11 time-out is not the fourth period");

  property p_rst_extra;
    @(posedge sys_clk) disable iff (!reset_n)
      wdt_rst_timeout == wdt_int_timeout + 27'h0000200;
  endproperty
  a_rst_extra: assert property (p_rst_extra)
    else $error("reset time-out is not 512 past interrupt time-out");

  property p_external_data_move;
    @(posedge sys_clk) disable iff (!reset_n)
      $stable(stretch_value) |-> external_data_move_cycles == {1'b0, stretch_value} + 4'h2;
  endproperty
  a_external_data_move: assert property (p_external_data_move)
    else $error("data move length is not stretch plus two");

  property p_stretch_write;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == tsc_pkg::ADDR_CLK_CTRL)
        |=> stretch_value == $past(reg_wdata[2:0]);
  endproperty
  a_stretch_write: assert property (p_stretch_write)
    else $error("stretch select not stored");

  property p_reset_default;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> stretch_value == 3'h1 && external_data_move_cycles == 4'h3;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("stretch default is not one");

  property p_t3_sel0;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_q.pre_sel == 2'h0)[*3] |-> t3_count_en;
  endproperty
  a_t3_sel0: assert property (p_t3_sel0)
    else $error("undivided timer 3 enable missing");

  property p_wdt_fire;
    @(posedge sys_clk) disable iff (!reset_n)
      wdt_reset_pulse |-> $past(s_q.wdt_cnt) + 27'h0000001
                          >= $past(s_q.rst_to);
  endproperty
  a_wdt_fire: assert property (p_wdt_fire)
    else $error("watchdog reset fired before its time-out");

  property p_stat_set;
    @(posedge sys_clk) disable iff (!reset_n)
      t3_count_en |=> s_q.irq_stat[tsc_pkg::IRQ_T3_TICK];
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("count enable event did not set its status bit");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!reset_n)
      irq == |(s_q.irq_stat & s_q.irq_mask)
        && (!irq || s_q.irq_mask != 3'h0);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level wrong");

  // The counter restarts from zero, so a second pulse cannot follow at once
  property p_rst_pulse_one;
    @(posedge sys_clk) disable iff (!reset_n)
      wdt_reset_pulse |=> !wdt_reset_pulse;
  endproperty
  a_rst_pulse_one: assert property (p_rst_pulse_one)
    else $error("watchdog reset pulse longer than one cycle");

  property p_wdt_stat;
    @(posedge sys_clk) disable iff (!reset_n)
      wdt_reset_pulse |-> s_q.irq_stat[tsc_pkg::IRQ_WDT_RST];
  endproperty
  a_wdt_stat: assert property (p_wdt_stat)
    else $error("watchdog reset did not flag its status bit");

  property p_int_event;
    @(posedge sys_clk) disable iff (!reset_n)
      (!wdt_restart && s_q.wdt_cnt + 27'h0000001 < s_q.rst_to
        && s_q.wdt_cnt + 27'h0000001 == s_q.int_to)
        |=> s_q.irq_stat[tsc_pkg::IRQ_WDT_INT];
  endproperty
  a_int_event: assert property (p_int_event)
    else $error("interrupt time-out did not flag its status bit");

  property p_external_data_move_range;
    @(posedge sys_clk) disable iff (!reset_n)
      external_data_move_cycles >= 4'h2 && external_data_move_cycles <= 4'h9;
  endproperty
  a_external_data_move_range: assert property (p_external_data_move_range)
    else $error("data move length outside two to nine");

  property p_stretch_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      !(reg_wr && reg_addr == tsc_pkg::ADDR_CLK_CTRL)
        |=> $stable(stretch_value);
  endproperty
  a_stretch_hold: assert property (p_stretch_hold)
    else $error("stretch select changed without a write");

  property p_t3_sel_write;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == tsc_pkg::ADDR_T3_PRESCALE)
        |=> s_q.pre_sel == $past(reg_wdata[1:0]);
  endproperty
  a_t3_sel_write: assert property (p_t3_sel_write)
    else $error("prescale select not stored");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (!reset_n)
      !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read strobe");

endmodule : tsc_timing_select
